// ===== rtl/ist_pkg.sv
// ==========================================================
// Shared constants for the I2C slave with bus time-out
package ist_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_MCR  = 8'h00;  // module_control_register
   localparam logic [7:0] OFF_BSC  = 8'h04;  // bus_status_control_register
   localparam logic [7:0] OFF_DATA = 8'h08;  // shift_data_register
   localparam logic [7:0] OFF_OWN  = 8'h0C;  // own_address_register
   localparam logic [7:0] OFF_TOC  = 8'h10;  // i2c_timeout_control

   // ==========================================================
   // Module control fields
   localparam int unsigned MCR_MODE_LSB = 5;
   localparam int unsigned MCR_EN_BIT   = 1;
   localparam logic [2:0]  MODE_I2C     = 3'h6;
   localparam logic [7:0]  MCR_WMASK    = 8'hEE;
   localparam logic [7:0]  MCR_RST      = 8'h00;

   // ==========================================================
   // Bus status / control fields
   localparam int unsigned BSC_HCF_BIT   = 7;
   localparam int unsigned BSC_ADDRESS_MATCH_FLAG_BIT  = 6;
   localparam int unsigned BSC_BUSY_BIT  = 5;
   localparam int unsigned BSC_HTX_BIT   = 4;
   localparam int unsigned BSC_ACK_TO_SEND_BIT  = 3;
   localparam int unsigned BSC_SRW_BIT   = 2;
   localparam int unsigned BSC_IAMWU_BIT = 1;
   localparam int unsigned BSC_ACK_RECEIVED_BIT  = 0;
   localparam logic [7:0]  BSC_RST       = 8'h81;

   // ==========================================================
   // Own address, data and time-out control fields
   localparam int unsigned OWN_LSB      = 0;
   localparam logic [6:0]  OWN_RST      = 7'h00;
   localparam logic [7:0]  DATA_RST     = 8'h00;
   localparam int unsigned TOC_EN_BIT   = 7;
   localparam int unsigned TOC_TOF_BIT  = 6;
   localparam int unsigned TOC_TOS_LSB  = 0;
   localparam logic [7:0]  TOC_RST      = 8'h00;

   // ==========================================================
   // Timing and framing counts
   localparam int unsigned SUB_DIV      = 32;
   localparam logic [4:0]  PRE_MAX      = 5'(SUB_DIV - 1);
   localparam logic [3:0]  BYTE_BITS    = 4'h8;
   localparam logic [2:0]  SYNC_RST     = 3'h3;  // Sub low, SDA and SCL idle high

   // ==========================================================
   // Slave sequencer states
   typedef enum logic [2:0] {
      IST_IDLE,
      IST_ADDR,
      IST_ADDR_ACK,
      IST_HOLD,
      IST_XFER,
      IST_ACK,
      IST_WAIT_STOP
   } ist_state_t;

endpackage : ist_pkg

// ===== rtl/ist_line_sync.sv
`timescale 1ns/100ps
// ==========================================================
// Pin synchroniser and bus condition detector
module ist_line_sync (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Raw inputs
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic sub_clk,
   // Synchronised levels and events
   output logic      scl_s,
   output logic      sda_s,
   output logic      scl_rise,
   output logic      scl_fall,
   output logic      start_det,
   output logic      stop_det,
   output logic      sub_tick
);
   import ist_pkg::*;

   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic [2:0] prev_q;
   logic [2:0] rise_w;
   logic [2:0] fall_w;

   // Edge of a sampled vector
   function automatic logic [2:0] edge_of(input logic [2:0] now, input logic [2:0] was);
      edge_of = now & ~was;
   endfunction : edge_of

   // Two-stage synchroniser plus history stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= SYNC_RST;
         sync_q <= SYNC_RST;
         prev_q <= SYNC_RST;
      end else begin
         meta_q <= {sub_clk, sda_i, scl_i};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Event decode from synchronised levels only
   assign rise_w    = edge_of(sync_q, prev_q);
   assign fall_w    = edge_of(prev_q, sync_q);
   assign scl_s     = sync_q[0];
   assign sda_s     = sync_q[1];
   assign scl_rise  = rise_w[0];
   assign scl_fall  = fall_w[0];
   assign start_det = fall_w[1] & sync_q[0] & prev_q[0];
   assign stop_det  = rise_w[1] & sync_q[0] & prev_q[0];
   assign sub_tick  = rise_w[2];

   // Checks
   a_start_cond: assert property (@(posedge hclk) disable iff (!hresetn)
      start_det |-> scl_s && !sda_s && $past(sda_s)) else $error("start without SDA fall at SCL high");
   a_scl_fall_edge: assert property (@(posedge hclk) disable iff (!hresetn)
      scl_fall |-> !scl_s ##1 !scl_rise) else $error("SCL fall decode wrong");

endmodule : ist_line_sync

// ===== rtl/ist_slave.sv
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
// ==========================================================
// Function
// - SDA falling while SCL high is a start; bus busy flag sets.
// - First seven bits after start compared with own address; match raises interrupt.
// - Eighth address bit stored as master read flag.
// - On match, pull SDA low on ninth clock and set address match flag.
// - One interrupt for address match, byte done or time-out.
// - After match, hold SCL low until data write (transmit) or read (receive).
// - Software sets transmit select from master read flag; slave follows it.
// - Data bytes are eight bits, most significant bit first.
// - Receiving, drive ack-to-send level on ninth clock; low acknowledges.
// - Transmitting, record master ack; on no ack release SDA, await stop.
// - Time-out counter starts on start plus match, clears on SCL fall.
// - Time-out when period passes before next SCL fall; stop halts counting.
// - On time-out counter stops, enable clears, flag sets, interrupt raised.
// - Time-out resets bus status register; data, address, module control kept.
// - Time-out flag cleared only by software.
// - Period is (field plus one) times 32 sub-clock periods.
// - Bus busy flag clears on stop.
// - Transfer done flag low while moving, high with interrupt after byte.
module ist_slave (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // I2C pins, open drain
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   // Sub clock for time-out
   input  wire logic        sub_clk,
   // Event pulse
   output logic             i2c_int
);
   import ist_pkg::*;

   // ==========================================================
   // Declarations
   logic        wr_pend_q;
   logic [7:0]  waddr_q;
   logic [7:0]  mcr_q;
   logic [6:0]  own_q;
   logic [7:0]  data_q;
   logic        hcf_q, address_match_flag_q, busy_q, htx_q, ack_to_send_q, srw_q, iamwu_q, ack_received_q;
   logic        toen_q, tof_q;
   logic [5:0]  tos_q;
   logic        to_run_q;
   logic [4:0]  pre_q;
   logic [5:0]  per_q;
   logic        int_q;
   ist_state_t  st_q, st_d;
   logic [3:0]  bitcnt_q, bitcnt_d;
   logic [7:0]  shift_q, shift_d;
   logic        scl_oe_q, scl_oe_d;
   logic        sda_oe_q, sda_oe_d;
   logic        ev_match, ev_byte, ack_smp, hcf_clr;
   logic        scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, sub_tick;

   // ==========================================================
   // Pin synchroniser
   ist_line_sync u_sync (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .sub_clk   (sub_clk),
      .scl_s     (scl_s),
      .sda_s     (sda_s),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det),
      .sub_tick  (sub_tick)
   );

   // ==========================================================
   // Bus decode
   wire        addr_ok  = hsel & hready & htrans[1];
   wire [7:0]  aoff     = haddr[7:0];
   wire        rd_go    = addr_ok & ~hwrite;
   wire        wr_mcr   = wr_pend_q & (waddr_q == OFF_MCR);
   wire        wr_bsc   = wr_pend_q & (waddr_q == OFF_BSC);
   wire        wr_data  = wr_pend_q & (waddr_q == OFF_DATA);
   wire        wr_own   = wr_pend_q & (waddr_q == OFF_OWN);
   wire        wr_toc   = wr_pend_q & (waddr_q == OFF_TOC);
   wire        rd_data  = rd_go & (aoff == OFF_DATA);
   wire [7:0]  bsc_rd   = {hcf_q, address_match_flag_q, busy_q, htx_q, ack_to_send_q, srw_q, iamwu_q, ack_received_q};
   wire [7:0]  toc_rd   = {toen_q, tof_q, tos_q};
   wire [7:0]  rd_mux   = (aoff == OFF_MCR)  ? mcr_q :
                          (aoff == OFF_BSC)  ? bsc_rd :
                          (aoff == OFF_DATA) ? data_q :
                          (aoff == OFF_OWN)  ? {1'b0, own_q} :
                          (aoff == OFF_TOC)  ? toc_rd : 8'h00;

   // Zero wait state, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ==========================================================
   // Slave control decode
   wire active     = mcr_q[MCR_EN_BIT] & (mcr_q[MCR_MODE_LSB +: 3] == MODE_I2C);
   wire byte_end   = scl_fall & (bitcnt_q == BYTE_BITS);
   wire addr_hit   = (shift_q[7:1] == own_q);
   wire sw_release = (st_q == IST_HOLD) & ((htx_q & wr_data) | (~htx_q & rd_data));
   wire to_fire    = to_run_q & sub_tick & (pre_q == PRE_MAX) & (per_q == tos_q);
   wire soft_rst   = to_fire | ~active;

   assign scl_o   = 1'b0;
   assign sda_o   = 1'b0;
   assign scl_oe  = scl_oe_q;
   assign sda_oe  = sda_oe_q;
   assign i2c_int = int_q;

   // ==========================================================
   // Bus address phase capture and read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         waddr_q   <= 8'h00;
         hrdata    <= 32'h0000_0000;
      end else begin
         wr_pend_q <= addr_ok & hwrite;
         waddr_q   <= aoff;
         if (rd_go) begin
            hrdata <= {24'h00_0000, rd_mux};
         end
      end
   end

   // ==========================================================
   // Sequencer next state
   always_comb begin
      st_d     = st_q;
      bitcnt_d = bitcnt_q;
      shift_d  = shift_q;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      ev_match = 1'b0;
      ev_byte  = 1'b0;
      ack_smp  = 1'b0;
      hcf_clr  = 1'b0;
      if (soft_rst) begin
         st_d     = IST_IDLE;
         bitcnt_d = 4'h0;
         scl_oe_d = 1'b0;
         sda_oe_d = 1'b0;
      end else if (start_det) begin
         st_d     = IST_ADDR;
         bitcnt_d = 4'h0;
         scl_oe_d = 1'b0;
         sda_oe_d = 1'b0;
      end else if (stop_det) begin
         st_d     = IST_IDLE;
         scl_oe_d = 1'b0;
         sda_oe_d = 1'b0;
      end else begin
         case (st_q)
            IST_IDLE: begin
               st_d = IST_IDLE;
            end
            IST_ADDR: begin
               if (scl_rise) begin
                  shift_d  = {shift_q[6:0], sda_s};
                  bitcnt_d = 4'(bitcnt_q + 4'h1);
               end else if (byte_end) begin
                  if (addr_hit) begin
                     st_d     = IST_ADDR_ACK;
                     sda_oe_d = 1'b1;
                     ev_match = 1'b1;
                  end else begin
                     st_d = IST_WAIT_STOP;
                  end
               end
            end
            IST_ADDR_ACK: begin
               if (scl_fall) begin
                  sda_oe_d = 1'b0;
                  scl_oe_d = 1'b1;
                  bitcnt_d = 4'h0;
                  st_d     = IST_HOLD;
               end
            end
            IST_HOLD: begin
               if (sw_release) begin
                  scl_oe_d = 1'b0;
                  hcf_clr  = 1'b1;
                  st_d     = IST_XFER;
                  if (htx_q) begin
                     shift_d  = hwdata[7:0];
                     sda_oe_d = ~hwdata[7];
                  end
               end
            end
            IST_XFER: begin
               if (scl_rise) begin
                  bitcnt_d = 4'(bitcnt_q + 4'h1);
                  if (!htx_q) begin
                     shift_d = {shift_q[6:0], sda_s};
                  end
               end else if (byte_end) begin
                  ev_byte  = 1'b1;
                  st_d     = IST_ACK;
                  sda_oe_d = htx_q ? 1'b0 : ~ack_to_send_q;
               end else if (scl_fall && htx_q) begin
                  shift_d  = {shift_q[6:0], 1'b0};
                  sda_oe_d = ~shift_q[6];
               end
            end
            IST_ACK: begin
               if (scl_rise) begin
                  ack_smp = 1'b1;
               end else if (scl_fall) begin
                  sda_oe_d = 1'b0;
                  if (htx_q && ack_received_q) begin
                     st_d = IST_WAIT_STOP;
                  end else begin
                     scl_oe_d = 1'b1;
                     bitcnt_d = 4'h0;
                     st_d     = IST_HOLD;
                  end
               end
            end
            IST_WAIT_STOP: begin
               st_d = IST_WAIT_STOP;
            end
            default: begin
               st_d = IST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Sequencer registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q     <= IST_IDLE;
         bitcnt_q <= 4'h0;
         shift_q  <= 8'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         int_q    <= 1'b0;
      end else begin
         st_q     <= st_d;
         bitcnt_q <= bitcnt_d;
         shift_q  <= shift_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         int_q    <= ev_match | ev_byte | to_fire;
      end
   end

   // ==========================================================
   // Configuration registers kept through a time-out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mcr_q  <= MCR_RST;
         own_q  <= OWN_RST;
         data_q <= DATA_RST;
      end else begin
         if (wr_mcr) mcr_q <= hwdata[7:0] & MCR_WMASK;
         if (wr_own) own_q <= hwdata[OWN_LSB +: 7];
         if (ev_byte && !htx_q) begin
            data_q <= shift_q;  // Received byte wins over a write
         end else if (wr_data) begin
            data_q <= hwdata[7:0];
         end
      end
   end

   // ==========================================================
   // Bus flags, returned to reset values by a time-out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {hcf_q, address_match_flag_q, busy_q, srw_q, ack_received_q} <= {BSC_RST[BSC_HCF_BIT], BSC_RST[BSC_ADDRESS_MATCH_FLAG_BIT],
            BSC_RST[BSC_BUSY_BIT], BSC_RST[BSC_SRW_BIT], BSC_RST[BSC_ACK_RECEIVED_BIT]};
      end else if (soft_rst) begin
         {hcf_q, address_match_flag_q, busy_q, srw_q, ack_received_q} <= {BSC_RST[BSC_HCF_BIT], BSC_RST[BSC_ADDRESS_MATCH_FLAG_BIT],
            BSC_RST[BSC_BUSY_BIT], BSC_RST[BSC_SRW_BIT], BSC_RST[BSC_ACK_RECEIVED_BIT]};
      end else begin
         if (start_det) busy_q <= 1'b1;
         else if (stop_det) busy_q <= 1'b0;
         if (ev_match) address_match_flag_q <= 1'b1;
         else if (start_det) address_match_flag_q <= 1'b0;
         if (ev_match) srw_q <= shift_q[0];
         else if (wr_bsc) srw_q <= hwdata[BSC_SRW_BIT];
         if (ev_byte || ev_match) hcf_q <= 1'b1;
         else if (hcf_clr || start_det) hcf_q <= 1'b0;
         if (ack_smp && htx_q) ack_received_q <= sda_s;
      end
   end

   // Software bits of bus status register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {htx_q, ack_to_send_q, iamwu_q} <= {BSC_RST[BSC_HTX_BIT], BSC_RST[BSC_ACK_TO_SEND_BIT], BSC_RST[BSC_IAMWU_BIT]};
      end else if (to_fire) begin
         {htx_q, ack_to_send_q, iamwu_q} <= {BSC_RST[BSC_HTX_BIT], BSC_RST[BSC_ACK_TO_SEND_BIT], BSC_RST[BSC_IAMWU_BIT]};
      end else if (wr_bsc) begin
         {htx_q, ack_to_send_q, iamwu_q} <= {hwdata[BSC_HTX_BIT], hwdata[BSC_ACK_TO_SEND_BIT], hwdata[BSC_IAMWU_BIT]};
      end
   end

   // ==========================================================
   // Time-out control and counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {toen_q, tof_q, tos_q} <= TOC_RST;
      end else begin
         if (to_fire) toen_q <= 1'b0;
         else if (wr_toc) toen_q <= hwdata[TOC_EN_BIT];
         if (to_fire) tof_q <= 1'b1;
         else if (wr_toc) tof_q <= hwdata[TOC_TOF_BIT];
         if (wr_toc) tos_q <= hwdata[TOC_TOS_LSB +: 6];
      end
   end

   // Prescaler by 32 sub ticks, then period count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         to_run_q <= 1'b0;
         pre_q    <= 5'h00;
         per_q    <= 6'h00;
      end else begin
         if (soft_rst || stop_det) to_run_q <= 1'b0;
         else if (ev_match && toen_q) to_run_q <= 1'b1;
         if (scl_fall || ev_match) begin
            pre_q <= 5'h00;
            per_q <= 6'h00;
         end else if (to_run_q && sub_tick) begin
            pre_q <= 5'(pre_q + 5'h01);
            if (pre_q == PRE_MAX) per_q <= 6'(per_q + 6'h01);
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_start_busy: assert property (start_det && !soft_rst |=> busy_q) else $error("busy not set on start");
   a_stop_free: assert property (stop_det && !start_det |=> !busy_q) else $error("busy not cleared");
   a_match_ack: assert property (ev_match |=> address_match_flag_q && sda_oe && (st_q == IST_ADDR_ACK)) else $error("no ack on match");
   a_srw_store: assert property (ev_match |=> srw_q == $past(shift_q[0])) else $error("read flag wrong");
   a_hold_scl: assert property ((st_q == IST_HOLD) && !sw_release && !soft_rst && !start_det && !stop_det
      |=> scl_oe) else $error("SCL released early");
   a_rx_ack_lvl: assert property (ev_byte && !htx_q && !soft_rst |=> sda_oe == !ack_to_send_q) else $error("ack level wrong");
   a_event_int: assert property (ev_byte || ev_match |=> i2c_int && hcf_q) else $error("no event on byte");
   a_timeout_eff: assert property (to_fire |=> tof_q && !toen_q && !to_run_q && !busy_q && hcf_q ##0 i2c_int)
      else $error("time-out effects missing");
   a_tof_sticky: assert property (tof_q && !wr_toc |=> tof_q) else $error("time-out flag lost");
   a_scl_fall_clr: assert property (scl_fall |=> pre_q == 5'h00 && per_q == 6'h00) else $error("counter not cleared");
   a_no_tx_noack: assert property ((st_q == IST_ACK) && scl_fall && htx_q && ack_received_q && !soft_rst && !start_det
      && !stop_det |=> !sda_oe && !scl_oe) else $error("line held after no ack");

   c_addr_match: cover property (ev_match);
   c_rx_byte: cover property (ev_byte && !htx_q);
   c_tx_byte: cover property (ev_byte && htx_q);
   c_timeout: cover property (to_fire);

endmodule : ist_slave

// ===== tb/ist_master_model.sv
`timescale 1ns/100ps
// ==========================================================
// I2C bus master model, open drain, honours clock holding
module ist_master_model (
   // Clock
   hclk,
   // Bus wires
   scl,
   sda,
   // Pull-low drives and hang flag
   scl_low,
   sda_low,
   hang
);
   input  wire logic hclk;
   input  wire logic scl;
   input  wire logic sda;
   output logic      scl_low = 1'b0;
   output logic      sda_low = 1'b0;
   output logic      hang = 1'b0;

   // Wait a number of system clocks
   task automatic hw(input int n);
      repeat (n) @(posedge hclk);
   endtask : hw

   // Release SCL, wait while the slave holds it low, then high half
   task automatic rise();
      int k;
      scl_low <= 1'b0;
      for (k = 0; k < 400 && scl !== 1'b1; k++) @(posedge hclk);
      if (k == 400) hang <= 1'b1;
      hw(12);
   endtask : rise

   // Start: SDA falls while SCL high, made only here
   task automatic start();
      sda_low <= 1'b0;
      hw(1);
      rise();
      sda_low <= 1'b1;
      hw(12);
      scl_low <= 1'b1;
   endtask : start

   // Nine clocks, MSB first, bit 0 is the acknowledge slot
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      int i;
      for (i = 8; i >= 0; i--) begin
         sda_low <= ~tx[i];
         hw(12);
         rise();
         rx[i] = sda;
         scl_low <= 1'b1;
      end
      // Let the slave see the last fall before software acts on it
      hw(6);
   endtask : xfer

   // Stop: SDA rises while SCL high
   task automatic stop();
      sda_low <= 1'b1;
      hw(12);
      rise();
      sda_low <= 1'b0;
      hw(12);
   endtask : stop
endmodule : ist_master_model

// ===== tb/tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the I2C slave with bus time-out
module tb_top;
   import ist_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sub_clk = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, i2c_int;
   logic        m_scl_low, m_sda_low, hang, rd_ph = 1'b0;
   wire         scl, sda;
   int          errors = 0, checked = 0, ints = 0;
   logic [7:0]  exp_q[$], msk_q[$];
   localparam logic [7:0] RA [6] = '{OFF_MCR, OFF_BSC, OFF_DATA, OFF_OWN, OFF_TOC, 8'h14};
   localparam logic [7:0] RV [6] = '{MCR_RST, BSC_RST, DATA_RST, 8'h00, TOC_RST, 8'h00};

   // Open-drain wires with pull-ups
   assign scl = ~(m_scl_low | (scl_oe & ~scl_o));
   assign sda = ~(m_sda_low | (sda_oe & ~sda_o));

   ist_slave ist_slave_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .sub_clk(sub_clk), .i2c_int(i2c_int));
   ist_master_model ist_master_model_i (.hclk(hclk), .scl(scl), .sda(sda), .scl_low(m_scl_low),
      .sda_low(m_sda_low), .hang(hang));

   // Clocks: 200 MHz system, 10 MHz sub clock of unrelated phase
   initial begin
      forever #2.5 hclk = ~hclk;
   end
   initial begin
      #37;
      forever #50 sub_clk = ~sub_clk;
   end

   task automatic end_sim();
      $display("Checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Bounded wait for hready at the next edges
   task automatic rdy();
      int k;
      @(posedge hclk);
      for (k = 0; k < 20 && hreadyout !== 1'b1; k++) @(posedge hclk);
      if (k == 20) begin
         errors++;
         end_sim();
      end
   endtask : rdy

   // Single AHB transfer; a read notes its expected value and mask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      rd_ph <= ~w;
      if (!w) begin
         exp_q.push_back(d);
         msk_q.push_back(m);
      end
      rdy();
      rd_ph <= 1'b0;
   endtask : ahb

   // Read data monitor against the oldest note
   always @(posedge hclk)
      if (rd_ph === 1'b1 && hreadyout === 1'b1)
         chk(hrdata & {24'hFFFFFF, msk_q.pop_front()}, {24'h0, exp_q.pop_front()});

   // Interrupt pulse counter and master hang
   always @(posedge hclk)
      if (i2c_int === 1'b1) ints <= ints + 1;
   always @(posedge hang) begin
      errors++;
      end_sim();
   end

   // Main sequence
   initial begin
      logic [8:0] r;
      logic [6:0] own;
      logic [7:0] d0, d1;
      int n;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      void'($urandom(51091));
      own = 7'($urandom());
      d0 = 8'($urandom());
      d1 = 8'($urandom());
      for (n = 0; n < 6; n++) ahb(1'b0, RA[n], RV[n], 8'hFF);
      chk(hresp, 0);
      ahb(1'b1, OFF_MCR, 8'hC2, 8'h00);
      ahb(1'b1, OFF_OWN, {1'b0, own}, 8'h00);
      // Master writes two bytes, second one refused by ack level
      ist_master_model_i.start();
      ahb(1'b0, OFF_BSC, 8'h20, 8'hA0);
      ist_master_model_i.xfer({own, 1'b0, 1'b1}, r);
      chk(r[0], 0);
      chk(ints, 1);
      ahb(1'b0, OFF_BSC, 8'hC0, 8'hC4);
      chk(scl_oe, 1);
      ahb(1'b1, OFF_BSC, 8'h00, 8'h00);
      ahb(1'b0, OFF_DATA, 8'h00, 8'h00);
      ist_master_model_i.xfer({d0, 1'b1}, r);
      chk(r[0], 0);
      ahb(1'b0, OFF_DATA, d0, 8'hFF);
      ahb(1'b1, OFF_BSC, 8'h08, 8'h00);
      ist_master_model_i.xfer({d1, 1'b1}, r);
      chk(r[0], 1);
      chk(ints, 3);
      ahb(1'b0, OFF_DATA, d1, 8'hFF);
      ist_master_model_i.stop();
      ahb(1'b0, OFF_BSC, 8'h00, 8'h20);
      // Master reads two bytes, refuses the second
      ist_master_model_i.start();
      ist_master_model_i.xfer({own, 1'b1, 1'b1}, r);
      chk(r[0], 0);
      ahb(1'b0, OFF_BSC, 8'h44, 8'h44);
      ahb(1'b1, OFF_BSC, 8'h10, 8'h00);
      ahb(1'b1, OFF_DATA, d0, 8'h00);
      ist_master_model_i.xfer({8'hFF, 1'b0}, r);
      chk(r[8:1], d0);
      ahb(1'b0, OFF_BSC, 8'h00, 8'h01);
      ahb(1'b1, OFF_DATA, d1, 8'h00);
      ist_master_model_i.xfer(9'h1FF, r);
      chk(r[8:1], d1);
      repeat (8) @(posedge hclk);
      chk({scl_oe, sda_oe}, 0);
      ahb(1'b0, OFF_BSC, 8'h01, 8'h01);
      chk(ints, 6);
      ist_master_model_i.stop();
      // Foreign address is ignored
      ist_master_model_i.start();
      ist_master_model_i.xfer({own ^ 7'h01, 1'b0, 1'b1}, r);
      chk(r[0], 1);
      ist_master_model_i.stop();
      chk(ints, 6);
      // Time-out with the clock left low, period field 2
      ahb(1'b1, OFF_TOC, 8'h82, 8'h00);
      ist_master_model_i.start();
      ist_master_model_i.xfer({own, 1'b0, 1'b1}, r);
      for (n = 0; n < 3000 && i2c_int !== 1'b1; n++) @(posedge hclk);
      chk(n > 1860 && n < 1980, 1);
      repeat (2) @(posedge hclk);
      chk(scl_oe, 0);
      ahb(1'b0, OFF_TOC, 8'h42, 8'hFF);
      ahb(1'b0, OFF_BSC, BSC_RST, 8'hFF);
      ahb(1'b0, OFF_OWN, {1'b0, own}, 8'hFF);
      ahb(1'b0, OFF_MCR, 8'hC2, 8'hFF);
      chk(ints, 8);
      ist_master_model_i.stop();
      ahb(1'b0, OFF_TOC, 8'h42, 8'hFF);
      ahb(1'b1, OFF_TOC, 8'h02, 8'h00);
      ahb(1'b0, OFF_TOC, 8'h02, 8'hFF);
      end_sim();
   end
endmodule : tb_top
